// >>> tlm_top.sv
// Functional notes
// - one window of each type active; other codes and ROM get nothing.
// - each window backed by 2 KB; higher addresses wrap onto it.
// - I/O window off by default, enabled by a parameter.
// - single-dword memory and I/O reads and writes handled correctly.
// - longer requests fully accepted, dropped, no completion.
// - every accepted I/O write gets a completion without data.
// - every accepted read gets a completion with data.
// - write: take data and address, pick region, then write enable.
// - read: take address, pick region, then read enable.
// - code 000b selects the I/O region memory.
// - code 010b selects the 32-bit memory region.
// - ready held low while a write to memory is in progress.
// - ready held low until read done and completion generated.
// - ready drops after last beat; next read only after completion sent.
// - next write accepted only after write-busy falls.
// - datapath buildable at 64, 128 or 256 bits.
// - 128-bit datapath not allowed for x8 at 8.0 Gb/s with 500 MHz.
// - write payload lands in the addressed word of the selected region.
`timescale 1ns/10ps
`default_nettype none

package tlm_pkg;
  // request descriptor layout (first 128 bits of a request packet)
  localparam int DESC_W       = 128;
  localparam int CAP_W        = 256;
  localparam int F_ADDR_LSB   = 2;
  localparam int F_DWCNT_LSB  = 64;
  localparam int F_TYPE_LSB   = 75;
  localparam int F_RID_LSB    = 80;
  localparam int F_TAG_LSB    = 96;
  localparam int F_BAR_LSB    = 112;
  localparam int F_TC_LSB     = 121;
  localparam int F_ATTR_LSB   = 124;
  localparam int F_DATA_LSB   = 128;
  localparam int DWCNT_W      = 11;
  localparam int WORD_W       = 32;
  localparam int IDX_W        = 9;
  localparam int REGION_WORDS = 512;
  localparam int NUM_REGIONS  = 3;
  localparam int MEM_WORDS    = NUM_REGIONS * REGION_WORDS;
  // request type encodings
  localparam logic [3:0] REQ_MRD = 4'h0;
  localparam logic [3:0] REQ_MWR = 4'h1;
  localparam logic [3:0] REQ_IORD = 4'h2;
  localparam logic [3:0] REQ_IOWR = 4'h3;
  // window match codes
  localparam logic [2:0] WIN_IO   = 3'h0;
  localparam logic [2:0] WIN_M64  = 3'h1;
  localparam logic [2:0] WIN_M32  = 3'h2;
  localparam logic [2:0] WIN_EROM = 3'h6;
  // region selects
  localparam logic [1:0] RG_IO   = 2'h0;
  localparam logic [1:0] RG_M32  = 2'h1;
  localparam logic [1:0] RG_M64  = 2'h2;
  localparam logic [1:0] RG_NONE = 2'h3;
  // completion descriptor layout, data dword above it
  localparam int CPL_W        = 128;
  localparam int C_LADDR_LSB  = 0;
  localparam int C_BCNT_LSB   = 16;
  localparam int C_DWCNT_LSB  = 32;
  localparam int C_STAT_LSB   = 43;
  localparam int C_RID_LSB    = 48;
  localparam int C_TAG_LSB    = 64;
  localparam int C_TC_LSB     = 87;
  localparam int C_ATTR_LSB   = 90;
  localparam int C_DATA_LSB   = 96;
  localparam int KEEP_W       = 4;
  localparam int CQ_ENTRY_W   = CPL_W + KEEP_W;
  localparam logic [12:0] BCNT_ONE  = 13'h004;
  localparam logic [10:0] DWCNT_ONE = 11'h001;
  localparam logic [2:0]  STAT_OK   = 3'h0;
  localparam logic [3:0]  KEEP_DATA   = 4'hF;
  localparam logic [3:0]  KEEP_NODATA = 4'h7;
  localparam int FIFO_DEPTH = 8;
  // datapath options and the one forbidden combination
  localparam int DP_64  = 64;
  localparam int DP_128 = 128;
  localparam int DP_256 = 256;
  localparam int BAD_LANES   = 8;
  localparam int BAD_RATE_X10 = 80;
  localparam int BAD_CLK_MHZ = 500;
endpackage

module tlm_top #(
  parameter bit IO_EN        = 1'b0,
  parameter int DP_W         = 64,
  parameter int LANES        = 1,
  parameter int LANE_RATE_X10 = 25,
  parameter int USER_CLK_MHZ = 250
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       cq_valid,
  input  wire logic [DP_W-1:0]            cq_data,
  input  wire logic                       cq_last,
  output logic                            request_stream_ready,
  output logic                            cc_valid,
  output logic [tlm_pkg::CPL_W-1:0]       cc_data,
  output logic [tlm_pkg::KEEP_W-1:0]      cc_keep,
  input  wire logic                       cc_ready,
  output logic                            wr_busy,
  output logic                            compl_done,
  output logic                            req_dropped
);
  localparam int BEATS_MAX = tlm_pkg::CAP_W / DP_W;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_WRITE,
    ST_READ,
    ST_CPL,
    ST_SENT
  } tlm_state_t;

  typedef struct packed {
    logic [tlm_pkg::MEM_WORDS-1:0][tlm_pkg::WORD_W-1:0] mem;
    tlm_state_t                                         st;
    logic [2:0]                                         cnt;
    logic [tlm_pkg::CAP_W-1:0]                          cap;
    logic [1:0]                                         region;
    logic [tlm_pkg::IDX_W-1:0]                          idx;
    logic [tlm_pkg::WORD_W-1:0]                         rdata;
    logic                                               is_read;
    logic                                               is_io;
    logic                                               rdy;
    logic                                               wr_busy;
    logic                                               done;
    logic                                               dropped;
  } tlm_top_state_t;

  // window code to region; one of each kind, ROM and spare codes unmapped
  function automatic logic [1:0] region_of(input logic [2:0] code, input logic io_on);
    logic [1:0] rg;
    rg = tlm_pkg::RG_NONE;
    unique case (code)
      tlm_pkg::WIN_IO:  rg = io_on ? tlm_pkg::RG_IO : tlm_pkg::RG_NONE;
      tlm_pkg::WIN_M32: rg = tlm_pkg::RG_M32;
      tlm_pkg::WIN_M64: rg = tlm_pkg::RG_M64;
      default:          rg = tlm_pkg::RG_NONE;
    endcase
    return rg;
  endfunction

  tlm_top_state_t                 r;
  tlm_top_state_t                 nxt;
  logic                           beat_take;
  logic [tlm_pkg::DWCNT_W-1:0]    d_len;
  logic [3:0]                     d_type;
  logic [2:0]                     d_win;
  logic [1:0]                     d_region;
  logic                           d_known;
  logic [10:0]                    mem_idx;
  logic [tlm_pkg::WORD_W-1:0]     wr_word;
  logic [tlm_pkg::WORD_W-1:0]     rd_word;
  logic [tlm_pkg::CPL_W-1:0]      cpl_word;
  logic [tlm_pkg::KEEP_W-1:0]     cpl_keep;
  logic                           cpl_push;
  logic                           fifo_in_ready;
  logic                           cpl_sent;

  // descriptor fields pulled from the captured header
  assign d_len    = r.cap[tlm_pkg::F_DWCNT_LSB +: tlm_pkg::DWCNT_W];
  assign d_type   = r.cap[tlm_pkg::F_TYPE_LSB +: 4];
  assign d_win    = r.cap[tlm_pkg::F_BAR_LSB +: 3];
  assign d_region = region_of(d_win, IO_EN);
  assign d_known  = (d_type == tlm_pkg::REQ_MRD) || (d_type == tlm_pkg::REQ_MWR)
                 || (d_type == tlm_pkg::REQ_IORD) || (d_type == tlm_pkg::REQ_IOWR);
  assign wr_word  = r.cap[tlm_pkg::F_DATA_LSB +: tlm_pkg::WORD_W];
  assign mem_idx  = {r.region, r.idx};
  assign rd_word  = r.mem[mem_idx];
  assign cpl_sent = cc_valid && cc_ready;

  // completion header mirrors the requester fields of the held request
  always_comb begin
    cpl_word = '0;
    cpl_word[tlm_pkg::C_LADDR_LSB +: 7]  = {r.cap[tlm_pkg::F_ADDR_LSB +: 5], 2'h0};
    cpl_word[tlm_pkg::C_BCNT_LSB +: 13]  = tlm_pkg::BCNT_ONE;
    cpl_word[tlm_pkg::C_STAT_LSB +: 3]   = tlm_pkg::STAT_OK;
    cpl_word[tlm_pkg::C_RID_LSB +: 16]   = r.cap[tlm_pkg::F_RID_LSB +: 16];
    cpl_word[tlm_pkg::C_TAG_LSB +: 8]    = r.cap[tlm_pkg::F_TAG_LSB +: 8];
    cpl_word[tlm_pkg::C_TC_LSB +: 3]     = r.cap[tlm_pkg::F_TC_LSB +: 3];
    cpl_word[tlm_pkg::C_ATTR_LSB +: 3]   = r.cap[tlm_pkg::F_ATTR_LSB +: 3];
    if (r.is_read) begin
      cpl_word[tlm_pkg::C_DWCNT_LSB +: tlm_pkg::DWCNT_W] = tlm_pkg::DWCNT_ONE;
      cpl_word[tlm_pkg::C_DATA_LSB +: tlm_pkg::WORD_W]   = r.rdata;
      cpl_keep = tlm_pkg::KEEP_DATA;
    end else begin
      cpl_keep = tlm_pkg::KEEP_NODATA;
    end
  end

  // receive engine and memory access; memory lives in the same state copy
  always_comb begin
    nxt         = r;
    beat_take   = cq_valid && r.rdy;
    cpl_push    = 1'b0;
    nxt.done    = cpl_sent;
    nxt.dropped = 1'b0;
    unique case (r.st)
      ST_IDLE: begin
        if (beat_take) begin
          if (int'(r.cnt) < BEATS_MAX) begin
            nxt.cap[int'(r.cnt) * DP_W +: DP_W] = cq_data;
          end
          if (r.cnt != 3'h7) begin
            nxt.cnt = r.cnt + 3'h1;
          end
          if (cq_last) begin
            nxt.st  = ST_DECODE;
            nxt.cnt = 3'h0;
          end
        end
      end
      ST_DECODE: begin
        // the code is checked: unmapped windows, long and unknown requests are dropped
        nxt.region  = d_region;
        nxt.idx     = r.cap[tlm_pkg::F_ADDR_LSB +: tlm_pkg::IDX_W];
        nxt.is_read = (d_type == tlm_pkg::REQ_MRD) || (d_type == tlm_pkg::REQ_IORD);
        nxt.is_io   = (d_type == tlm_pkg::REQ_IORD) || (d_type == tlm_pkg::REQ_IOWR);
        if (d_len != tlm_pkg::DWCNT_ONE || d_region == tlm_pkg::RG_NONE || !d_known) begin
          nxt.st      = ST_IDLE;
          nxt.dropped = 1'b1;
        end else if (nxt.is_read) begin
          nxt.st = ST_READ;
        end else begin
          nxt.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        nxt.mem[mem_idx] = wr_word;
        nxt.st = r.is_io ? ST_CPL : ST_IDLE;
      end
      ST_READ: begin
        nxt.rdata = rd_word;
        nxt.st    = ST_CPL;
      end
      ST_CPL: begin
        // waits on the queue so a stalled completion path stalls requests
        if (fifo_in_ready) begin
          cpl_push = 1'b1;
          nxt.st   = ST_SENT;
        end
      end
      ST_SENT: begin
        if (cpl_sent) begin
          nxt.st = ST_IDLE;
        end
      end
    endcase
    nxt.rdy     = (nxt.st == ST_IDLE);
    nxt.wr_busy = (nxt.st == ST_WRITE);
  end

  // memory words are left out of reset: contents are undefined at power up
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r.mem     <= nxt.mem;
      r.st      <= ST_IDLE;
      r.cnt     <= 3'h0;
      r.cap     <= '0;
      r.region  <= tlm_pkg::RG_NONE;
      r.idx     <= '0;
      r.rdata   <= '0;
      r.is_read <= 1'b0;
      r.is_io   <= 1'b0;
      r.rdy     <= 1'b0;
      r.wr_busy <= 1'b0;
      r.done    <= 1'b0;
      r.dropped <= 1'b0;
    end else begin
      r <= nxt;
    end
  end

  // eight-deep completion queue toward the core's completion stream
  tlm_fifo #(
    .W     (tlm_pkg::CQ_ENTRY_W),
    .DEPTH (tlm_pkg::FIFO_DEPTH)
  ) u_cpl_fifo (
    .clk       (ref_clk),
    .rst       (rst),
    .in_valid  (cpl_push),
    .in_data   ({cpl_keep, cpl_word}),
    .in_ready  (fifo_in_ready),
    .out_valid (cc_valid),
    .out_data  ({cc_keep, cc_data}),
    .out_ready (cc_ready)
  );

  assign request_stream_ready = r.rdy;
  assign wr_busy              = r.wr_busy;
  assign compl_done           = r.done;
  assign req_dropped          = r.dropped;

  // checks
  a_dp_width_ok: assert property (@(posedge ref_clk)
    (DP_W == tlm_pkg::DP_64) || (DP_W == tlm_pkg::DP_128) || (DP_W == tlm_pkg::DP_256))
    else $error("datapath width not 64, 128 or 256");

  a_dp_bad_combo: assert property (@(posedge ref_clk)
    !(DP_W == tlm_pkg::DP_128 && LANES == tlm_pkg::BAD_LANES
      && LANE_RATE_X10 == tlm_pkg::BAD_RATE_X10 && USER_CLK_MHZ == tlm_pkg::BAD_CLK_MHZ))
    else $error("128-bit datapath not allowed for this link setup");

  a_ready_write_low: assert property (@(posedge ref_clk) disable iff (rst)
    wr_busy |-> !request_stream_ready ##1 (!request_stream_ready || !wr_busy))
    else $error("ready high during memory write");

  a_ready_read_low: assert property (@(posedge ref_clk) disable iff (rst)
    (r.st == ST_READ) |-> !request_stream_ready [*3])
    else $error("ready high during read processing");

  a_last_beat_stall: assert property (@(posedge ref_clk) disable iff (rst)
    (cq_valid && request_stream_ready && cq_last)
      |=> !request_stream_ready ##1 (!request_stream_ready || req_dropped))
    else $error("ready not dropped after last beat");

  a_read_wait_sent: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(request_stream_ready) && $past(r.st) == ST_SENT) |-> $past(cpl_sent))
    else $error("ready returned before completion sent");

  a_write_busy_rel: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(wr_busy) && !r.is_io |-> request_stream_ready)
    else $error("ready not back when write busy fell");

  a_long_dropped: assert property (@(posedge ref_clk) disable iff (rst)
    (r.st == ST_DECODE && d_len != tlm_pkg::DWCNT_ONE)
      |=> req_dropped && r.st == ST_IDLE ##1 !cc_valid)
    else $error("long request not dropped");

  a_io_region_sel: assert property (@(posedge ref_clk) disable iff (rst)
    (r.st == ST_DECODE && d_win == tlm_pkg::WIN_IO && d_len == tlm_pkg::DWCNT_ONE)
      |=> (IO_EN ? (r.region == tlm_pkg::RG_IO) : req_dropped))
    else $error("window code 000b misrouted");

  a_m32_region_sel: assert property (@(posedge ref_clk) disable iff (rst)
    (r.st == ST_DECODE && d_win == tlm_pkg::WIN_M32) |=> r.region == tlm_pkg::RG_M32)
    else $error("window code 010b misrouted");

  a_mem_write_data: assert property (@(posedge ref_clk) disable iff (rst)
    (r.st == ST_WRITE) |=> r.mem[$past(mem_idx)] == $past(wr_word))
    else $error("write data not stored");

  a_read_cpl_data: assert property (@(posedge ref_clk) disable iff (rst)
    (r.st == ST_READ) |=> (r.rdata == $past(rd_word)) ##[1:2]
      (cc_valid && cc_keep == tlm_pkg::KEEP_DATA
       && cc_data[tlm_pkg::C_DATA_LSB +: tlm_pkg::WORD_W] == r.rdata))
    else $error("read completion missing or wrong");

  a_iowr_cpl_nodata: assert property (@(posedge ref_clk) disable iff (rst)
    (r.st == ST_WRITE && r.is_io) |=> ##[1:2] (cc_valid && cc_keep == tlm_pkg::KEEP_NODATA))
    else $error("io write completion missing");
endmodule

`default_nettype wire

// >>> tlm_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module tlm_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
    logic [CNT_W-1:0]        cnt;
    logic                    in_rdy;
    logic                    out_vld;
  } tlm_fifo_state_t;

  tlm_fifo_state_t r;
  tlm_fifo_state_t nxt;
  logic            push;
  logic            pop;

  // head always sits in entry 0 so the output is a plain flop
  always_comb begin
    nxt  = r;
    push = in_valid && r.in_rdy;
    pop  = r.out_vld && out_ready;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        nxt.ent[i] = r.ent[i+1];
      end
    end
    if (push) begin
      nxt.ent[CNT_W'(r.cnt - CNT_W'(pop))] = in_data;
    end
    nxt.cnt     = CNT_W'(r.cnt + CNT_W'(push) - CNT_W'(pop));
    nxt.in_rdy  = (nxt.cnt != CNT_W'(DEPTH));
    nxt.out_vld = (nxt.cnt != '0);
  end

  // no reset on entries: contents are don't-care while not counted
  always_ff @(posedge clk) begin
    if (rst) begin
      r.ent     <= nxt.ent;
      r.cnt     <= '0;
      r.in_rdy  <= 1'b0;
      r.out_vld <= 1'b0;
    end else begin
      r <= nxt;
    end
  end

  assign in_ready  = r.in_rdy;
  assign out_valid = r.out_vld;
  assign out_data  = r.ent[0];
endmodule

`default_nettype wire

// >>> tlm_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// behavioural endpoint core: issues request packets and sinks completions
module tlm_core_model #(
  parameter int DP_W = 64
) (
  input  wire logic                        ref_clk,
  output logic                             cq_valid,
  output logic [DP_W-1:0]                  cq_data,
  output logic                             cq_last,
  input  wire logic                        request_stream_ready,
  input  wire logic                        cc_valid,
  input  wire logic [tlm_pkg::CPL_W-1:0]   cc_data,
  input  wire logic [tlm_pkg::KEEP_W-1:0]  cc_keep,
  output logic                             cc_ready
);
  int                         cc_delay = 0;
  int                         hangs    = 0;
  int                         wait_n   = 0;
  logic [tlm_pkg::CPL_W-1:0]  cpl_q[$];
  logic [tlm_pkg::KEEP_W-1:0] keep_q[$];

  // idle stream at time zero
  initial begin
    cq_valid = 1'b0;
    cq_data  = '0;
    cq_last  = 1'b0;
    cc_ready = 1'b0;
  end

  // callers may hand over packets that miss every window; beats low first, each held till taken
  task automatic send_pkt(input logic [tlm_pkg::CAP_W-1:0] pkt, input int nb);
    int w;
    for (int b = 0; b < nb; b++) begin
      cq_valid = 1'b1;
      cq_data  = pkt[b*DP_W +: DP_W];
      cq_last  = (b == nb - 1);
      w = 0;
      while (!request_stream_ready && w < 100) begin
        @(negedge ref_clk);
        w++;
      end
      if (w == 100) hangs++;
      @(negedge ref_clk);
    end
    cq_valid = 1'b0;
    cq_last  = 1'b0;
    cq_data  = ~cq_data; // a released bus must not look like the last beat
  endtask

  // ready after cc_delay cycles of valid, so a slow sink can be modelled
  always @(negedge ref_clk) begin
    if (cc_valid && !cc_ready && wait_n >= cc_delay) cc_ready <= 1'b1;
    else if (cc_valid && !cc_ready) wait_n <= wait_n + 1;
    else begin
      cc_ready <= 1'b0;
      wait_n   <= 0;
    end
  end

  // keep every completion taken
  always @(posedge ref_clk) begin
    if (cc_valid && cc_ready) begin
      cpl_q.push_back(cc_data);
      keep_q.push_back(cc_keep);
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam int DW = 64;
  typedef struct {
    logic [3:0]  typ;
    logic [2:0]  code;
    logic [31:0] addr;
    logic [10:0] dw;
    logic [31:0] data;  // payload of a write, expected word of a read
    logic        cpl;
  } tlm_row_t;

  logic                          ref_clk;
  logic                          rst;
  logic                          cq_valid;
  logic [DW-1:0]                 cq_data;
  logic                          cq_last;
  logic                          request_stream_ready;
  logic                          cc_valid;
  logic [tlm_pkg::CPL_W-1:0]     cc_data;
  logic [tlm_pkg::KEEP_W-1:0]    cc_keep;
  logic                          cc_ready;
  logic                          wr_busy;
  logic                          compl_done;
  logic                          req_dropped;
  logic                          rdy_noio;
  logic                          drop_noio;
  int                            drops_noio = 0;
  int                            num_errors = 0;
  int                            compares   = 0;
  int                            drops      = 0;
  int                            busies     = 0;
  int                            dones      = 0;

  tlm_row_t rows[12] = '{
    '{tlm_pkg::REQ_MWR,  3'h2, 32'h0000_0014, 11'h001, 32'hA5A5_0001, 1'b0},
    '{tlm_pkg::REQ_MRD,  3'h2, 32'h0000_0014, 11'h001, 32'hA5A5_0001, 1'b1},
    '{tlm_pkg::REQ_MWR,  3'h1, 32'h0000_0814, 11'h001, 32'h5A5A_0002, 1'b0},
    '{tlm_pkg::REQ_MRD,  3'h1, 32'h0000_0014, 11'h001, 32'h5A5A_0002, 1'b1},
    '{tlm_pkg::REQ_IOWR, 3'h0, 32'h0000_07FC, 11'h001, 32'h1234_5678, 1'b1},
    '{tlm_pkg::REQ_IORD, 3'h0, 32'h0000_07FC, 11'h001, 32'h1234_5678, 1'b1},
    '{tlm_pkg::REQ_MWR,  3'h2, 32'h0000_0014, 11'h002, 32'hDEAD_0003, 1'b0},
    '{tlm_pkg::REQ_MWR,  3'h6, 32'h0000_0014, 11'h001, 32'h0BAD_0004, 1'b0},
    '{tlm_pkg::REQ_MRD,  3'h3, 32'h0000_0014, 11'h001, 32'h0000_0000, 1'b0},
    '{4'h5,              3'h2, 32'h0000_0014, 11'h001, 32'h0BAD_0005, 1'b0},  // unknown type
    '{tlm_pkg::REQ_MRD,  3'h2, 32'h0000_0014, 11'h001, 32'hA5A5_0001, 1'b1},
    '{tlm_pkg::REQ_MRD,  3'h2, 32'hFFFF_F014, 11'h001, 32'hA5A5_0001, 1'b1}
  };

  tlm_top #(.IO_EN(1'b1), .DP_W(DW)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .cq_valid(cq_valid), .cq_data(cq_data),
    .cq_last(cq_last), .request_stream_ready(request_stream_ready),
    .cc_valid(cc_valid), .cc_data(cc_data), .cc_keep(cc_keep), .cc_ready(cc_ready),
    .wr_busy(wr_busy), .compl_done(compl_done), .req_dropped(req_dropped)
  );

  // default build keeps the io window off; runs in step, must drop every io access
  tlm_top #(.DP_W(DW)) u_dut_noio (
    .ref_clk(ref_clk), .rst(rst), .cq_valid(cq_valid), .cq_data(cq_data),
    .cq_last(cq_last), .request_stream_ready(rdy_noio),
    .cc_valid(), .cc_data(), .cc_keep(), .cc_ready(cc_ready),
    .wr_busy(), .compl_done(), .req_dropped(drop_noio)
  );

  tlm_core_model #(.DP_W(DW)) u_core (
    .ref_clk(ref_clk), .cq_valid(cq_valid), .cq_data(cq_data), .cq_last(cq_last),
    .request_stream_ready(request_stream_ready), .cc_valid(cc_valid),
    .cc_data(cc_data), .cc_keep(cc_keep), .cc_ready(cc_ready)
  );

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // pulse counters, and ready must stay low while a write or completion is pending
  always @(negedge ref_clk) begin
    if (req_dropped === 1'b1) drops++;
    if (wr_busy === 1'b1) busies++;
    if (compl_done === 1'b1) dones++;
    if (drop_noio === 1'b1) drops_noio++;
    if (!rst && request_stream_ready && (wr_busy || cc_valid)) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, request_stream_ready, 1'b0);
    end
  end

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("counts: compares=%0d mismatches=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic logic [255:0] mk_pkt(tlm_row_t r, logic [7:0] tag);
    logic [255:0] p;
    p = '0;
    p[tlm_pkg::F_ADDR_LSB +: 30]  = r.addr[31:2];
    p[tlm_pkg::F_DWCNT_LSB +: 11] = r.dw;
    p[tlm_pkg::F_TYPE_LSB +: 4]   = r.typ;
    p[tlm_pkg::F_RID_LSB +: 16]   = 16'hC1A3;
    p[tlm_pkg::F_TAG_LSB +: 8]    = tag;
    p[tlm_pkg::F_BAR_LSB +: 3]    = r.code;
    p[tlm_pkg::F_TC_LSB +: 3]     = 3'h5;
    p[tlm_pkg::F_ATTR_LSB +: 3]   = 3'h2;
    p[tlm_pkg::F_DATA_LSB +: 32]  = r.data;
    return p;
  endfunction

  // completion built from the request fields; an io write carries no data
  function automatic logic [127:0] exp_cpl(tlm_row_t r, logic [7:0] tag);
    logic [127:0] c;
    logic         io_wr;
    io_wr = (r.typ == tlm_pkg::REQ_IOWR);
    c = '0;
    c[tlm_pkg::C_LADDR_LSB +: 7]  = {r.addr[6:2], 2'b00};
    c[tlm_pkg::C_BCNT_LSB +: 13]  = tlm_pkg::BCNT_ONE;
    c[tlm_pkg::C_DWCNT_LSB +: 11] = io_wr ? 11'h000 : tlm_pkg::DWCNT_ONE;
    c[tlm_pkg::C_STAT_LSB +: 3]   = tlm_pkg::STAT_OK;
    c[tlm_pkg::C_RID_LSB +: 16]   = 16'hC1A3;
    c[tlm_pkg::C_TAG_LSB +: 8]    = tag;
    c[tlm_pkg::C_TC_LSB +: 3]     = 3'h5;
    c[tlm_pkg::C_ATTR_LSB +: 3]   = 3'h2;
    c[tlm_pkg::C_DATA_LSB +: 32]  = io_wr ? 32'h0000_0000 : r.data;
    return c;
  endfunction

  // one request, then wait till ready returns and compare what came back
  task automatic run_row(input tlm_row_t r, input logic [7:0] tag);
    int   n0;
    int   d0;
    int   b0;
    int   k0;
    int   d2;
    int   w;
    logic wr;
    logic drop;
    n0 = u_core.cpl_q.size();
    d0 = drops;
    b0 = busies;
    k0 = dones;
    d2 = drops_noio;
    wr = (r.typ == tlm_pkg::REQ_MWR) || (r.typ == tlm_pkg::REQ_IOWR);
    drop = (r.dw != 11'h001) || (r.code > 3'h2) || (r.typ > tlm_pkg::REQ_IOWR);
    u_core.send_pkt(mk_pkt(r, tag), drop && r.dw != 11'h001 ? 4 : (wr ? 3 : 2));
    w = 0;
    while (!request_stream_ready && w < 60) begin
      @(negedge ref_clk);
      w++;
    end
    @(negedge ref_clk);
    check(128'(w == 60 || u_core.hangs != 0), 128'h0);
    if (w == 60 || u_core.hangs != 0) wrap_up();
    check(128'(u_core.cpl_q.size() - n0), 128'(r.cpl));
    check(128'(dones - k0), 128'(r.cpl));
    check(128'(drops - d0), 128'(drop));
    check(128'(drops_noio - d2), 128'(drop || r.code == 3'h0));
    check(128'(busies - b0), 128'(wr && !drop));
    if (r.cpl && u_core.cpl_q.size() > n0) begin
      check(u_core.cpl_q[$], exp_cpl(r, tag));
      check(128'(u_core.keep_q[$]), r.typ == tlm_pkg::REQ_IOWR ?
            128'(tlm_pkg::KEEP_NODATA) : 128'(tlm_pkg::KEEP_DATA));
    end
    $display("test with tag %0d done", tag);
  endtask

  initial begin
    rst      = 1'b1;
    repeat (10) @(negedge ref_clk);
    check(128'({request_stream_ready, cc_valid}), 128'h0);
    rst = 1'b0;
    // table of requests, dropped ones included, back to back
    for (int i = 0; i < 12; i++) run_row(rows[i], 8'(i));
    // slow completion sink, two reads back to back
    u_core.cc_delay = 7;
    run_row(rows[1], 8'h40);
    run_row(rows[3], 8'h41);
    u_core.cc_delay = 0;
    // reset in mid-run: outputs quiet, memory kept
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    check(128'({request_stream_ready, cc_valid, wr_busy}), 128'h0);
    rst = 1'b0;
    run_row(rows[5], 8'h42);
    wrap_up();
  end
endmodule
`default_nettype wire
